// *** include/fscfg_cfg.svh ***
// Register map, field positions and reset values of the frame-sync / forwarding config bank.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef FSCFG_CFG_SVH
`define FSCFG_CFG_SVH
`define FSCFG_ADDR_W        8
`define FSCFG_OFF_FS_CTL    8'h18
`define FSCFG_OFF_HI1       8'h19
`define FSCFG_OFF_HI0       8'h1a
`define FSCFG_OFF_LO1       8'h1b
`define FSCFG_OFF_LO0       8'h1c
`define FSCFG_OFF_MAXHI     8'h1d
`define FSCFG_OFF_MAXLO     8'h1e
`define FSCFG_OFF_CLKCTL    8'h1f
`define FSCFG_OFF_FWD       8'h20
`define FSCFG_RST_ZERO      8'h00
`define FSCFG_RST_MAXLO     8'h04
`define FSCFG_RST_CLKCTL    8'h02
`define FSCFG_RST_FWD       8'hf0
`define FSCFG_MASK_CLKCTL   8'h0f
`define FSCFG_MASK_FWD      8'hf0
`define FSCFG_BIT_GEN_ON    0
`define FSCFG_BIT_SHAPE     1
`define FSCFG_BIT_INIT      2
`define FSCFG_BIT_CLKSEL    3
`define FSCFG_BIT_SRC_INT   6
`define FSCFG_BIT_OSC       3
`define FSCFG_BIT_REFMODE   2
`define FSCFG_FRAME_ONE     16'h0001
`define FSCFG_FRAME_ZERO    16'h0000
`define FSCFG_CNT_ZERO      24'h000000
`endif

// *** include/fscfg_pkg.sv ***
// Types of the frame-sync / forwarding config bank.
// Assumes fscfg_cfg.svh for all numeric constants.
package fscfg_pkg;
    typedef enum logic [1:0] {
        FSCFG_SPD_FAST  = 2'b00,
        FSCFG_SPD_1G2   = 2'b01,
        FSCFG_SPD_800M  = 2'b10,
        FSCFG_SPD_400M  = 2'b11
    } fscfg_speed_type;

    typedef struct packed {
        logic            internal_osc_select;
        logic            ref_clk_half;
        fscfg_speed_type tx_speed;
    } fscfg_clk_type;

    typedef struct packed {
        logic rx3_forward_off;
        logic rx2_forward_off;
        logic rx1_forward_off;
        logic rx0_forward_off;
    } fscfg_fwd_type;
endpackage

// *** design/fscfg_top.sv ***
// Frame-sync period registers, frame-number limit, clock control and forwarding disables,
// with the frame-sync generator and the raw-mode frame-number counter they drive.
// Assumes a synchronous register port and a one-cycle tick strobe per frame-clock source.
//
// Functional notes
// (R1) High count: low byte 7:0, high byte 15:8
// (R2) Low count: high byte 15:8, low byte 7:0
// (R3) Programmed count is duration minus one
// (R4) Frame number on every start/end packet
// (R5) Limit zero gives frame number zero
// (R6) Number counts one to limit, wraps to one
// (R7) Limit upper/lower bytes; lower resets 0x4
// (R8) Oscillator select: external or internal 200MHz
// (R9) Reference mode: 200 MHz or 100 MHz
// (R10) Software avoids 100 MHz with 400 Mbps
// (R11) Two-bit transmit speed, resets 800 Mbps
// (R12) Bits 7:4 disable ports 3..0, reset one
// (R13) High/low counts or balanced 24-bit count
// (R14) Enable bit starts and stops generation
// (R15) Count chosen frame-clock ticks, reload on toggle
`timescale 1ns/100ps
`include "fscfg_cfg.svh"
module fscfg_top (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rstn,
    input  wire logic [`FSCFG_ADDR_W-1:0]   i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire logic [4:0]                 i_frame_clk_tick,
    input  wire logic                       i_frame_start,
    output logic      [7:0]                 o_rdata,
    output logic                            o_frame_sync,
    output logic      [15:0]                o_frame_number,
    output fscfg_pkg::fscfg_clk_type        o_clk_ctl,
    output fscfg_pkg::fscfg_fwd_type        o_fwd_off
);

////////////////////////////////////////////////////////////////////////////////
logic [7:0]  fs_ctl_r;
logic [7:0]  hi1_r;
logic [7:0]  hi0_r;
logic [7:0]  lo1_r;
logic [7:0]  lo0_r;
logic [7:0]  maxhi_r;
logic [7:0]  maxlo_r;
logic [7:0]  clkctl_r;
logic [7:0]  fwd_r;
logic [7:0]  rdata_nxt;
logic [15:0] sync_high_count;
logic [15:0] sync_low_count;
logic [15:0] frame_limit;
logic [23:0] phase_cnt_r;
logic [23:0] reload_nxt;
logic        gen_on_d_r;
logic        tick;
logic [2:0]  src_sel;

// Reset images of the two registered control outputs
localparam logic [7:0] RST_CLK_IMG = `FSCFG_RST_CLKCTL;
localparam logic [7:0] RST_FWD_IMG = `FSCFG_RST_FWD;

assign sync_high_count = {hi1_r, hi0_r};    // R1
assign sync_low_count  = {lo1_r, lo0_r};    // R2
assign frame_limit     = {maxhi_r, maxlo_r}; // R7

////////////////////////////////////////////////////////////////////////////////
// Register writes
always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
        fs_ctl_r <= `FSCFG_RST_ZERO;
        hi1_r    <= `FSCFG_RST_ZERO;
        hi0_r    <= `FSCFG_RST_ZERO;
        lo1_r    <= `FSCFG_RST_ZERO;
        lo0_r    <= `FSCFG_RST_ZERO;
        maxhi_r  <= `FSCFG_RST_ZERO;    // R7
        maxlo_r  <= `FSCFG_RST_MAXLO;   // R7
        clkctl_r <= `FSCFG_RST_CLKCTL;  // R11
        fwd_r    <= `FSCFG_RST_FWD;     // R12
    end else if (i_wr) begin
        case (i_addr)
            `FSCFG_OFF_FS_CTL: fs_ctl_r <= i_wdata;
            `FSCFG_OFF_HI1:    hi1_r    <= i_wdata;
            `FSCFG_OFF_HI0:    hi0_r    <= i_wdata;
            `FSCFG_OFF_LO1:    lo1_r    <= i_wdata;
            `FSCFG_OFF_LO0:    lo0_r    <= i_wdata;
            `FSCFG_OFF_MAXHI:  maxhi_r  <= i_wdata;
            `FSCFG_OFF_MAXLO:  maxlo_r  <= i_wdata;
            `FSCFG_OFF_CLKCTL: clkctl_r <= i_wdata & `FSCFG_MASK_CLKCTL; // R8 R9 R11
            `FSCFG_OFF_FWD:    fwd_r    <= i_wdata & `FSCFG_MASK_FWD;    // R12
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read port, data one cycle after the strobe; unmapped reads zero
always_comb begin
    case (i_addr)
        `FSCFG_OFF_FS_CTL: rdata_nxt = fs_ctl_r;
        `FSCFG_OFF_HI1:    rdata_nxt = hi1_r;
        `FSCFG_OFF_HI0:    rdata_nxt = hi0_r;
        `FSCFG_OFF_LO1:    rdata_nxt = lo1_r;
        `FSCFG_OFF_LO0:    rdata_nxt = lo0_r;
        `FSCFG_OFF_MAXHI:  rdata_nxt = maxhi_r;
        `FSCFG_OFF_MAXLO:  rdata_nxt = maxlo_r;
        `FSCFG_OFF_CLKCTL: rdata_nxt = clkctl_r;
        `FSCFG_OFF_FWD:    rdata_nxt = fwd_r;
        default:           rdata_nxt = `FSCFG_RST_ZERO;
    endcase
end

always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
        o_rdata <= `FSCFG_RST_ZERO;
    end else if (i_rd) begin
        o_rdata <= rdata_nxt;
    end else begin
        o_rdata <= `FSCFG_RST_ZERO;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Clock control and forwarding outputs, registered
always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
        o_clk_ctl <= fscfg_pkg::fscfg_clk_type'(RST_CLK_IMG[3:0]);
        o_fwd_off <= fscfg_pkg::fscfg_fwd_type'(RST_FWD_IMG[7:4]);
    end else begin
        o_clk_ctl.internal_osc_select <= clkctl_r[`FSCFG_BIT_OSC];     // R8
        o_clk_ctl.ref_clk_half        <= clkctl_r[`FSCFG_BIT_REFMODE]; // R9
        o_clk_ctl.tx_speed            <= fscfg_pkg::fscfg_speed_type'(clkctl_r[1:0]); // R11
        o_fwd_off                     <= fscfg_pkg::fscfg_fwd_type'(fwd_r[7:4]);     // R12
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frame-sync generator
// Mode bits 7:4: 00xx back-channel port, 01xx internal tick (index 4)
assign src_sel = fs_ctl_r[`FSCFG_BIT_SRC_INT] ? 3'h4 : {1'b0, fs_ctl_r[5:4]};
assign tick    = i_frame_clk_tick[src_sel]; // R15

always_comb begin
    if (fs_ctl_r[`FSCFG_BIT_SHAPE]) begin
        reload_nxt = {hi0_r, lo1_r, lo0_r}; // R13
    end else if (o_frame_sync) begin
        reload_nxt = {8'h00, sync_low_count};  // R13
    end else begin
        reload_nxt = {8'h00, sync_high_count}; // R13
    end
end

always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
        o_frame_sync <= 1'b0;
        phase_cnt_r  <= `FSCFG_CNT_ZERO;
        gen_on_d_r   <= 1'b0;
    end else begin
        gen_on_d_r <= fs_ctl_r[`FSCFG_BIT_GEN_ON];
        if (!fs_ctl_r[`FSCFG_BIT_GEN_ON]) begin // R14
            o_frame_sync <= fs_ctl_r[`FSCFG_BIT_INIT];
            phase_cnt_r  <= `FSCFG_CNT_ZERO;
        end else if (!gen_on_d_r) begin
            phase_cnt_r <= fs_ctl_r[`FSCFG_BIT_SHAPE] ? {hi0_r, lo1_r, lo0_r} :
                           (o_frame_sync ? {8'h00, sync_high_count} : {8'h00, sync_low_count});
        end else if (tick) begin
            if (phase_cnt_r == `FSCFG_CNT_ZERO) begin // R3
                o_frame_sync <= ~o_frame_sync;
                phase_cnt_r  <= reload_nxt;           // R15
            end else begin
                phase_cnt_r <= phase_cnt_r - 24'h000001;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Raw-mode frame number for start and end short packets
always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
        o_frame_number <= `FSCFG_FRAME_ZERO;
    end else if (frame_limit == `FSCFG_FRAME_ZERO) begin
        o_frame_number <= `FSCFG_FRAME_ZERO; // R5
    end else if (i_frame_start) begin        // R4
        if (o_frame_number >= frame_limit || o_frame_number == `FSCFG_FRAME_ZERO) begin
            o_frame_number <= `FSCFG_FRAME_ONE; // R6
        end else begin
            o_frame_number <= o_frame_number + `FSCFG_FRAME_ONE; // R6
        end
    end
end

endmodule

// *** bench/fscfg_checker.sv ***
// Checker: port-level properties of the frame-sync config bank.
// Assumes it is bound onto fscfg_top; mirrors the frame-number limit.
`timescale 1ns/100ps
`include "fscfg_cfg.svh"
module fscfg_checker (
    input  wire logic [7:0]            i_wdata,
    input  wire logic [`FSCFG_ADDR_W-1:0] i_addr,
    input  wire logic                  i_mclk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic                  i_frame_start,
    input  wire logic [7:0]            o_rdata,
    input  wire logic [15:0]           o_frame_number,
    input  wire fscfg_pkg::fscfg_clk_type o_clk_ctl,
    input  wire fscfg_pkg::fscfg_fwd_type o_fwd_off
);
    logic [15:0] lim_r;
    default clocking cb @(posedge i_mclk); endclocking
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) lim_r <= {8'h00, `FSCFG_RST_MAXLO};
        else if (i_wr && i_addr == `FSCFG_OFF_MAXHI) lim_r[15:8] <= i_wdata;
        else if (i_wr && i_addr == `FSCFG_OFF_MAXLO) lim_r[7:0] <= i_wdata;
    end
    ////////////////////////////////////////////////////////////
    property p_clk; disable iff (!i_rstn)
        i_wr && i_addr == `FSCFG_OFF_CLKCTL |-> ##2 o_clk_ctl == $past(i_wdata[3:0], 2); endproperty
    a_clk: assert property (p_clk) else $error("clock control copy wrong");
    property p_fwd; disable iff (!i_rstn)
        i_wr && i_addr == `FSCFG_OFF_FWD |-> ##2 o_fwd_off == $past(i_wdata[7:4], 2); endproperty
    a_fwd: assert property (p_fwd) else $error("forward disable copy wrong");
    property p_rst; !i_rstn |=> o_clk_ctl == 4'h2 && o_fwd_off == 4'hf; endproperty
    a_rst: assert property (p_rst) else $error("output reset value wrong");
    property p_clk_rsv; disable iff (!i_rstn) i_rd && i_addr == `FSCFG_OFF_CLKCTL |=> o_rdata[7:4] == 4'h0; endproperty
    a_clk_rsv: assert property (p_clk_rsv) else $error("clock control upper bits nonzero");
    property p_fwd_rsv; disable iff (!i_rstn) i_rd && i_addr == `FSCFG_OFF_FWD |=> o_rdata[3:0] == 4'h0; endproperty
    a_fwd_rsv: assert property (p_fwd_rsv) else $error("forward lower bits nonzero");
    property p_lim0; disable iff (!i_rstn) $past(lim_r) == 16'h0 |-> o_frame_number == 16'h0; endproperty
    a_lim0: assert property (p_lim0) else $error("frame number not zero");
    property p_wrap; disable iff (!i_rstn)
        i_frame_start && lim_r != 16'h0 && o_frame_number >= lim_r |=> o_frame_number == 16'h1; endproperty
    a_wrap: assert property (p_wrap) else $error("frame number did not wrap");
    property p_step; disable iff (!i_rstn) i_frame_start && lim_r != 16'h0 && o_frame_number < lim_r
        |=> o_frame_number == $past(o_frame_number) + 16'h1; endproperty
    a_step: assert property (p_step) else $error("frame number did not advance");
endmodule
bind fscfg_top fscfg_checker u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_frame_start(i_frame_start), .o_rdata(o_rdata),
    .o_frame_number(o_frame_number), .o_clk_ctl(o_clk_ctl), .o_fwd_off(o_fwd_off));

// *** bench/framesync_csi_forward_config_test.sv ***
// Bench: register access, frame numbering and frame-sync periods.
// Assumes fscfg_top and its checker are compiled before it.
`timescale 1ns/100ps
module framesync_csi_forward_config_test;
    logic i_mclk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_frame_start = 0, o_frame_sync;
    logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
    logic [4:0] i_frame_clk_tick = 5'h10;
    logic [15:0] o_frame_number;
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'hf0};
    logic [7:0] wv [7] = '{8'hfe, 8'hfe, 8'hfe, 8'hfe, 8'hfe, 8'h0e, 8'hf0};
    logic [15:0] hc [2] = '{16'h0000, 16'h0100};
    logic [15:0] lc [2] = '{16'h0000, 16'h0102};
    fscfg_pkg::fscfg_clk_type o_clk_ctl;
    fscfg_pkg::fscfg_fwd_type o_fwd_off;
    int n_mismatch = 0, total_checks = 0, k, h;
    always #5 i_mclk = ~i_mclk;
    fscfg_top dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_frame_clk_tick(i_frame_clk_tick), .i_frame_start(i_frame_start), .o_rdata(o_rdata),
        .o_frame_sync(o_frame_sync), .o_frame_number(o_frame_number), .o_clk_ctl(o_clk_ctl), .o_fwd_off(o_fwd_off));
    ////////////////////////////////////////////////////////////
    task chk(input logic [15:0] s, input logic [15:0] x);
        total_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1; i_addr <= a; i_wdata <= d;
        @(posedge i_mclk) i_wr <= 0;
        @(posedge i_mclk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        i_rd <= 1; i_addr <= a;
        @(posedge i_mclk) i_rd <= 0;
        #1 chk(o_rdata, x);
        @(posedge i_mclk);
    endtask
    task fr(input logic [15:0] x);
        i_frame_start <= 1;
        @(posedge i_mclk) i_frame_start <= 0;
        #1 chk(o_frame_number, x);
        @(posedge i_mclk);
    endtask
    // Cycles the sync level stays at v
    task run(input logic v, output int n);
        n = 0;
        while (o_frame_sync === v && n < 600) begin
            @(posedge i_mclk);
            #1 n++;
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rstn <= 1;
        @(posedge i_mclk);
        for (k = 0; k < 7; k++) rd(8'h1a + k[7:0], rv[k]);
        for (k = 0; k < 6; k++) fr(16'(k % 4 + 1));
        wr(8'h1e, 8'h00);
        fr(16'h0000);
        wr(8'h1d, 8'h01);
        for (k = 0; k < 257; k++) fr(16'(k % 256 + 1));
        for (k = 0; k < 7; k++) wr(8'h1a + k[7:0], 8'hfe);
        for (k = 0; k < 7; k++) rd(8'h1a + k[7:0], wv[k]);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        for (k = 0; k < 16; k++) if (k[2:0] != 3'h7) begin
            wr(8'h1f, k[7:0]);
            #1 chk(o_clk_ctl, k[3:0]);
        end
        wr(8'h20, 8'h5a);
        #1 chk(o_fwd_off, 4'h5);
        for (k = 0; k < 2; k++) begin
            @(posedge i_mclk);
            wr(8'h18, 8'h00);
            wr(8'h19, hc[k][15:8]);
            wr(8'h1a, hc[k][7:0]);
            wr(8'h1b, lc[k][15:8]);
            wr(8'h1c, lc[k][7:0]);
            wr(8'h18, 8'h41);
            #1 run(0, h);
            run(1, h);
            chk(h[15:0], hc[k] + 16'h1);
            run(0, h);
            chk(h[15:0], lc[k] + 16'h1);
        end
        @(posedge i_mclk);
        wr(8'h18, 8'h00);
        @(posedge i_mclk);
        #1 chk(o_frame_sync, 1'b0);
        wr(8'h18, 8'h04);
        #1 chk(o_frame_sync, 1'b1);
        end_of_test;
    end
endmodule
